// *** hw/clock_generators_regs.svh ***
// register indices, field positions, reset values, pin codes and the external divisor
// for the fractional clock generator block.
// assumes: included by bare name; the byte address is four times an index.
`ifndef CLOCK_GENERATORS_REGS_SVH
`define CLOCK_GENERATORS_REGS_SVH

// -----------------------------------------------------------------------
// register indices (byte address = index * 4)
// -----------------------------------------------------------------------
`define CG_IDX_GEN1_DEN   18'h0f020
`define CG_IDX_GEN1_NUM   18'h0f021
`define CG_IDX_GEN2_DEN   18'h0f022
`define CG_IDX_GEN2_NUM   18'h0f023
`define CG_IDX_GEN3_SRC   18'h0f024
`define CG_IDX_GEN3_NUM   18'h0f025
`define CG_IDX_GEN3_DEN   18'h0f026
`define CG_IDX_GEN3_COUNT 18'h0f027

// -----------------------------------------------------------------------
// field positions and widths
// -----------------------------------------------------------------------
`define CG_RATIO_W        9
`define CG_SRC_EXT_BIT    4
`define CG_SRC_PIN_MSB    3
`define CG_ACC_W          11

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define CG_RST_GEN1_DEN   9'h006
`define CG_RST_GEN1_NUM   9'h001
`define CG_RST_GEN2_DEN   9'h009
`define CG_RST_GEN2_NUM   9'h001
`define CG_RST_GEN3_NUM   9'h001
`define CG_RST_GEN3_DEN   9'h001
`define CG_RST_SRC_EXT    1'h0
`define CG_RST_SRC_PIN    4'he

// -----------------------------------------------------------------------
// pin codes and the fixed external divisor
// -----------------------------------------------------------------------
`define CG_PIN_MASTER_SEL 4'h0
`define CG_PIN_SPDIF      4'he
`define CG_EXT_DIVISOR    11'h400

`endif

// *** hw/clock_generators_pkg.sv ***
// types shared by the fractional clock generator block.
// assumes: constants come from clock_generators_regs.svh.
package clock_generators_pkg;

    // bus answer phase; gray codes along idle, wait, done
    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_WAIT = 2'b01,
        APB_DONE = 2'b11
    } apb_state_t;

    // one generator's ratio
    typedef struct packed {
        logic [8:0] num;
        logic [8:0] den;
    } gen_cfg_t;

    // generator three's reference choice
    typedef struct packed {
        logic       ext;
        logic [3:0] pin;
    } gen3_src_t;

endpackage : clock_generators_pkg

// *** hw/fractional_clock_generators.sv ***
// apb register block and three fractional rate generators.
// assumes: pll_ref_tick_i is one pulse per pll reference period, and pin
// inputs are synchronous to clk_sys_i.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "clock_generators_regs.svh"

module fractional_clock_generators #(
    parameter int NUM_PINS = 14
) (
    // clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                resetn_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [19:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    input  wire logic [3:0]          pstrb_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // references
    input  wire logic                pll_ref_tick_i,
    input  wire logic [NUM_PINS-1:0] mp_pins_i,
    input  wire logic                spdif_ref_i,
    // generated rate ticks, one per output period
    output logic      [2:0]          gen_tick_o
);

    // -------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------

    // true when the address selects the given register index
    function automatic logic hit(input logic [19:0] addr,
                                 input logic [17:0] idx);
        hit = (addr[19:2] == idx);
    endfunction : hit

    // merge write data into a nine-bit field by byte lane
    function automatic logic [8:0] merge9(input logic [8:0]  old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
        logic [8:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            r[8] = wd[8];
        end
        merge9 = r;
    endfunction : merge9

    // one reference edge of a fractional divider: {tick, accumulator}
    function automatic logic [11:0] gen_step(
        input logic [10:0] acc,
        input logic [8:0]  num,
        input logic [10:0] den
    );
        logic [11:0] sum;
        sum = {1'b0, acc} + {3'h0, num};
        if (den == 11'h000) begin
            gen_step = {1'b0, acc};
        end else if (sum >= {den, 1'b0}) begin
            // remainder would stay at or above m (n above m, or m just
            // lowered): restart so the accumulator never runs away
            gen_step = {1'b1, 11'h000};
        end else if (sum >= {1'b0, den}) begin
            gen_step = {1'b1, 11'(sum - {1'b0, den})};
        end else begin
            gen_step = {1'b0, sum[10:0]};
        end
    endfunction : gen_step

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    clock_generators_pkg::apb_state_t apb_state;
    clock_generators_pkg::apb_state_t next_apb_state;
    clock_generators_pkg::gen_cfg_t   cfg [3];
    clock_generators_pkg::gen_cfg_t   next_cfg [3];
    clock_generators_pkg::gen3_src_t  src;
    clock_generators_pkg::gen3_src_t  next_src;
    logic [15:0]                      gen3_count;
    logic [15:0]                      next_gen3_count;
    logic [31:0]                      next_prdata;
    logic                             next_pready;
    logic                             next_pslverr;
    logic                             wr_en;
    logic                             mapped;
    logic                             ref_level;
    logic                             ref_prev;
    logic                             gen3_edge;
    logic [10:0]                      acc [3];
    logic [10:0]                      next_acc [3];
    logic [10:0]                      eff_den [3];
    logic [2:0]                       ref_tick;
    logic [2:0]                       next_tick;

    // -------------------------------------------------------------------
    // apb access
    // -------------------------------------------------------------------

    // address map check
    always_comb begin
        mapped = hit(paddr_i, `CG_IDX_GEN1_DEN)
               | hit(paddr_i, `CG_IDX_GEN1_NUM)
               | hit(paddr_i, `CG_IDX_GEN2_DEN)
               | hit(paddr_i, `CG_IDX_GEN2_NUM)
               | hit(paddr_i, `CG_IDX_GEN3_SRC)
               | hit(paddr_i, `CG_IDX_GEN3_NUM)
               | hit(paddr_i, `CG_IDX_GEN3_DEN)
               | hit(paddr_i, `CG_IDX_GEN3_COUNT);
        wr_en  = psel_i & penable_i & pready_o & pwrite_i & mapped;
    end

    // answer two cycles into the access phase, then release
    always_comb begin
        next_apb_state = apb_state;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        next_prdata    = 32'h0000_0000;
        case (apb_state)
            clock_generators_pkg::APB_IDLE: begin
                if (psel_i && penable_i) begin
                    next_apb_state = clock_generators_pkg::APB_WAIT;
                end
            end
            clock_generators_pkg::APB_WAIT: begin
                next_apb_state = clock_generators_pkg::APB_DONE;
                next_pready    = 1'b1;
                next_pslverr   = ~mapped;
                case (1'b1)
                    hit(paddr_i, `CG_IDX_GEN1_DEN):
                        next_prdata[8:0] = cfg[0].den;
                    hit(paddr_i, `CG_IDX_GEN1_NUM):
                        next_prdata[8:0] = cfg[0].num;
                    hit(paddr_i, `CG_IDX_GEN2_DEN):
                        next_prdata[8:0] = cfg[1].den;
                    hit(paddr_i, `CG_IDX_GEN2_NUM):
                        next_prdata[8:0] = cfg[1].num;
                    hit(paddr_i, `CG_IDX_GEN3_SRC):
                        next_prdata[4:0] = src;
                    hit(paddr_i, `CG_IDX_GEN3_NUM):
                        next_prdata[8:0] = cfg[2].num;
                    hit(paddr_i, `CG_IDX_GEN3_DEN):
                        next_prdata[8:0] = cfg[2].den;
                    hit(paddr_i, `CG_IDX_GEN3_COUNT):
                        next_prdata[15:0] = gen3_count;
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
            clock_generators_pkg::APB_DONE: begin
                next_apb_state = clock_generators_pkg::APB_IDLE;
            end
            default: begin
                next_apb_state = clock_generators_pkg::APB_IDLE;
            end
        endcase
    end

    // register writes; upper reserved bits are not stored and read zero
    always_comb begin
        next_cfg = cfg;
        next_src = src;
        if (wr_en) begin
            if (hit(paddr_i, `CG_IDX_GEN1_DEN)) begin
                next_cfg[0].den = merge9(cfg[0].den, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, `CG_IDX_GEN1_NUM)) begin
                next_cfg[0].num = merge9(cfg[0].num, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, `CG_IDX_GEN2_DEN)) begin
                next_cfg[1].den = merge9(cfg[1].den, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, `CG_IDX_GEN2_NUM)) begin
                next_cfg[1].num = merge9(cfg[1].num, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, `CG_IDX_GEN3_NUM)) begin
                next_cfg[2].num = merge9(cfg[2].num, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, `CG_IDX_GEN3_DEN)) begin
                next_cfg[2].den = merge9(cfg[2].den, pwdata_i, pstrb_i);
            end
            if (hit(paddr_i, `CG_IDX_GEN3_SRC) && pstrb_i[0]) begin
                next_src.ext = pwdata_i[`CG_SRC_EXT_BIT];
                next_src.pin = pwdata_i[`CG_SRC_PIN_MSB:0];
            end
        end
    end

    // bus and configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            apb_state  <= clock_generators_pkg::APB_IDLE;
            pready_o   <= 1'b0;
            pslverr_o  <= 1'b0;
            prdata_o   <= 32'h0000_0000;
            cfg[0]     <= {`CG_RST_GEN1_NUM, `CG_RST_GEN1_DEN};
            cfg[1]     <= {`CG_RST_GEN2_NUM, `CG_RST_GEN2_DEN};
            cfg[2]     <= {`CG_RST_GEN3_NUM, `CG_RST_GEN3_DEN};
            src        <= {`CG_RST_SRC_EXT, `CG_RST_SRC_PIN};
        end else begin
            apb_state  <= next_apb_state;
            pready_o   <= next_pready;
            pslverr_o  <= next_pslverr;
            prdata_o   <= next_prdata;
            cfg        <= next_cfg;
            src        <= next_src;
        end
    end

    // -------------------------------------------------------------------
    // generator three reference selection
    // -------------------------------------------------------------------

    // pick the reference pin; 1110 selects s/pdif, other codes past the pins give a low level
    always_comb begin
        ref_level = 1'b0;
        if (src.pin == `CG_PIN_SPDIF) begin
            ref_level = spdif_ref_i;
        end else if (32'(src.pin) < NUM_PINS) begin
            ref_level = mp_pins_i[src.pin];
        end
        gen3_edge = src.ext ? (ref_level & ~ref_prev) : pll_ref_tick_i;
    end

    // -------------------------------------------------------------------
    // fractional dividers
    // -------------------------------------------------------------------

    // references and effective denominators of each generator
    always_comb begin
        ref_tick   = {gen3_edge, pll_ref_tick_i, pll_ref_tick_i};
        eff_den[0] = {2'b00, cfg[0].den};
        eff_den[1] = {2'b00, cfg[1].den};
        eff_den[2] = src.ext ? `CG_EXT_DIVISOR
                             : {2'b00, cfg[2].den};
    end

    // one accumulator step per reference edge; at most one tick per edge
    for (genvar g = 0; g < 3; g++) begin : g_div
        always_comb begin
            logic [11:0] step;
            step        = gen_step(acc[g], cfg[g].num, eff_den[g]);
            next_acc[g] = acc[g];
            next_tick[g] = 1'b0;
            if (ref_tick[g]) begin
                next_acc[g]  = step[10:0];
                next_tick[g] = step[11];
            end
        end
    end

    // count generator three output ticks for software
    always_comb begin
        next_gen3_count = gen3_count + {15'h0000, next_tick[2]};
    end

    // divider registers
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            acc[0]     <= 11'h000;
            acc[1]     <= 11'h000;
            acc[2]     <= 11'h000;
            gen_tick_o <= 3'h0;
            ref_prev   <= 1'b0;
            gen3_count <= 16'h0000;
        end else begin
            acc        <= next_acc;
            gen_tick_o <= next_tick;
            ref_prev   <= ref_level;
            gen3_count <= next_gen3_count;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------

    chk_gen1_den_reset: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> cfg[0].den == 9'h006)
        else $error("generator one denominator reset wrong");

    chk_gen1_num_write: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (wr_en && hit(paddr_i, `CG_IDX_GEN1_NUM) && pstrb_i[1:0] == 2'b11)
        |=> cfg[0].num == $past(pwdata_i[8:0]) ##2 prdata_o[31:9] == 23'h0)
        else $error("generator one numerator write lost");

    chk_gen2_den_reset: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> cfg[1].den == 9'h009 && src.ext == 1'b0)
        else $error("generator two denominator reset wrong");

    chk_pll_ref_path: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (!src.ext && !pll_ref_tick_i) |=> $stable(acc[2]))
        else $error("generator three moved without a pll pulse");

    chk_pll_ratio_den: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (!src.ext && pll_ref_tick_i && cfg[2].den != 9'h000)
        |=> acc[2] < {2'b00, $past(cfg[2].den)})
        else $error("generator three accumulator past denominator");

    chk_ext_divisor: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        src.ext |-> eff_den[2] == 11'h400 ##1 acc[2] < 11'h400)
        else $error("external divisor not 1024");

    chk_pin_select: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (src.ext && src.pin < 4'he && 32'(src.pin) < NUM_PINS)
        |-> ref_level == mp_pins_i[src.pin])
        else $error("wrong reference pin");

    chk_pin_code_zero: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        ($rose(resetn_i) |-> src.pin == 4'he)
        and (src.pin == 4'h0 |-> ref_level == mp_pins_i[0]))
        else $error("pin code reset or code zero wrong");

    chk_spdif_select: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (src.ext && src.pin == 4'he && spdif_ref_i && !ref_prev)
        |-> gen3_edge)
        else $error("s/pdif edge not taken");

endmodule : fractional_clock_generators

// *** verification/ref_source_model.sv ***
// reference sources for the clock generators: pll pulses, pin clocks and
// the s/pdif receiver input.
// assumes: one clock; every source is synchronous to clk_sys_i.
`timescale 1ns/10ps
module ref_source_model #(
    parameter int PLL_PERIOD  = 4,
    parameter int SPDIF_HALF  = 9
) (
    // clock
    input  wire logic        clk_sys_i,
    // reference outputs
    output logic             pll_ref_tick_o = 1'b0,
    output logic [13:0]      mp_pins_o      = 14'h0000,
    output logic             spdif_ref_o    = 1'b0
);
    // -------------------------------------------------------------------
    // free running sources
    // -------------------------------------------------------------------
    int cyc = 0;

    // each pin gets its own rate so a wrong pin choice shows as a wrong rate
    always @(posedge clk_sys_i) begin
        cyc            <= cyc + 1;
        pll_ref_tick_o <= (cyc % PLL_PERIOD) == 0;
        for (int i = 0; i < 14; i++) begin
            mp_pins_o[i] <= ((cyc / (3 + i)) % 2) == 1;
        end
        spdif_ref_o    <= ((cyc / SPDIF_HALF) % 2) == 1;
    end
endmodule : ref_source_model

// *** verification/tb_fractional_clock_generators.sv ***
// self-checking bench for the fractional clock generators.
// assumes: register indices from clock_generators_regs.svh, apb answers
// within a few cycles.
`timescale 1ns/10ps
`include "clock_generators_regs.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb_fractional_clock_generators;
    // -------------------------------------------------------------------
    // signals
    // -------------------------------------------------------------------
    logic        clk_sys_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [19:0] paddr_i   = 20'h00000;
    logic [31:0] pwdata_i  = 32'h00000000;
    logic [3:0]  pstrb_i   = 4'hf;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        pll_ref_tick_i;
    logic [13:0] mp_pins_i;
    logic        spdif_ref_i;
    logic [2:0]  gen_tick_o;
    int          fails     = 0;
    int          checks    = 0;
    logic [31:0] rd;
    logic        err;
    logic [3:0]  codes [4] = '{4'h0, 4'h5, 4'hd, 4'he};

    always #4 clk_sys_i = ~clk_sys_i;

    fractional_clock_generators #(.NUM_PINS(14)) dut_u (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pll_ref_tick_i(pll_ref_tick_i), .mp_pins_i(mp_pins_i),
        .spdif_ref_i(spdif_ref_i), .gen_tick_o(gen_tick_o));

    ref_source_model src_u (
        .clk_sys_i(clk_sys_i), .pll_ref_tick_o(pll_ref_tick_i),
        .mp_pins_o(mp_pins_i), .spdif_ref_o(spdif_ref_i));

    // -------------------------------------------------------------------
    // apb master and helpers
    // -------------------------------------------------------------------
    // one transfer; request held until pready is sampled high, the
    // watchdog alone ends a wait that never finishes
    task automatic apb(input logic w, input logic [17:0] idx,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= {idx, 2'b00};
        pwdata_i  <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // read and compare one register
    task automatic rchk(input string nm, input logic [17:0] idx,
                        input logic [31:0] ex);
        apb(1'b0, idx, 32'h00000000);
        `CHK(nm, ex, rd)
    endtask : rchk

    // count reference events (src 15 = pll, 14 = s/pdif) and ticks
    task automatic window(input int cyc, input int src, output int ev,
                          output int t0, output int t1, output int t2);
        logic cur;
        logic prv;
        ev = 0; t0 = 0; t1 = 0; t2 = 0; prv = 1'b1;
        repeat (cyc) begin
            @(posedge clk_sys_i);
            cur = (src == 15) ? pll_ref_tick_i :
                  (src == 14) ? spdif_ref_i : mp_pins_i[src];
            ev += (src == 15) ? int'(cur) : int'(cur & ~prv);
            prv = cur;
            t0 += int'(gen_tick_o[0]);
            t1 += int'(gen_tick_o[1]);
            t2 += int'(gen_tick_o[2]);
        end
    endtask : window

    // tick count must match events * n / d within one
    task automatic rate(input string nm, input int ev, input int n,
                        input int d, input int t);
        int ex;
        ex = ev * n / d;
        `CHK(nm, 1'b1, (t + 1 >= ex) && (t <= ex + 1))
    endtask : rate

    // -------------------------------------------------------------------
    // verdict
    // -------------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        close_out;
    end

    // -------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------
    initial begin
        int ev, t0, t1, t2;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        // reset values
        rchk("gen1 den", `CG_IDX_GEN1_DEN, 32'h00000006);
        rchk("gen1 num", `CG_IDX_GEN1_NUM, 32'h00000001);
        rchk("gen2 den", `CG_IDX_GEN2_DEN, 32'h00000009);
        rchk("gen3 src", `CG_IDX_GEN3_SRC, 32'h0000000e);
        $display("test reset values done");
        // ones written (gen2 den gets fffffe5a), reserved bits read zero; unmapped index errors
        apb(1'b1, `CG_IDX_GEN1_DEN, 32'hffffffff);
        rchk("gen1 den", `CG_IDX_GEN1_DEN, 32'h000001ff);
        apb(1'b1, `CG_IDX_GEN1_NUM, 32'hffffffff);
        rchk("gen1 num", `CG_IDX_GEN1_NUM, 32'h000001ff);
        apb(1'b1, `CG_IDX_GEN2_DEN, 32'hfffffe5a);
        rchk("gen2 den", `CG_IDX_GEN2_DEN, 32'h0000005a);
        apb(1'b1, `CG_IDX_GEN3_SRC, 32'hffffffff);
        rchk("gen3 src", `CG_IDX_GEN3_SRC, 32'h0000001f);
        apb(1'b0, 18'h0f028, 32'h00000000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, rd)
        $display("test register access done");
        // pll reference rates for all three generators
        apb(1'b1, `CG_IDX_GEN1_DEN, 32'h00000006);
        apb(1'b1, `CG_IDX_GEN1_NUM, 32'h00000001);
        apb(1'b1, `CG_IDX_GEN2_DEN, 32'h00000009);
        apb(1'b1, `CG_IDX_GEN2_NUM, 32'h00000001);
        apb(1'b1, `CG_IDX_GEN3_SRC, 32'h0000000e);
        apb(1'b1, `CG_IDX_GEN3_NUM, 32'h00000002);
        apb(1'b1, `CG_IDX_GEN3_DEN, 32'h00000005);
        window(800, 15, ev, t0, t1, t2);
        rate("gen1 rate", ev, 1, 6, t0);
        rate("gen2 rate", ev, 1, 9, t1);
        rate("gen3 pll rate", ev, 2, 5, t2);
        $display("test pll rates done");
        // external references (pins 0, 5, 13 and s/pdif); m left at 1 must not matter
        apb(1'b1, `CG_IDX_GEN3_NUM, 32'h00000100);
        apb(1'b1, `CG_IDX_GEN3_DEN, 32'h00000001);
        foreach (codes[k]) begin
            apb(1'b1, `CG_IDX_GEN3_SRC, {27'h0, 1'b1, codes[k]});
            window(1200, int'(codes[k]), ev, t0, t1, t2);
            rate("gen3 pin rate", ev, 256, 1024, t2);
        end
        $display("test external references done");
        close_out;
    end
endmodule : tb_fractional_clock_generators
